// File: rtl/lft_cfg.svh
/*
  constants for the line/frame timing and standby block: offsets, fields, codes, resets.
  assumes inclusion by bare name from the timing module.
*/
`ifndef LFT_CFG_SVH
`define LFT_CFG_SVH

`define LFT_ADDR_HOST_PORT 8'h00
`define LFT_ADDR_TIMING 8'h04
`define LFT_ADDR_STATUS 8'h08
`define LFT_ADDR_WIDTH 8'h0c

`define LFT_PORT_INSTR_BIT 8
`define LFT_CMD_SYSTEM_SETUP 8'h40
`define LFT_CMD_STANDBY_ENTRY 8'h53
`define LFT_CMD_DISPLAY_ENABLE 8'h59

`define LFT_PIDX_FIRST 4'h0
`define LFT_PIDX_LINE_BYTES 4'h3
`define LFT_PIDX_LINE_LEN 4'h4
`define LFT_PIDX_FRAME_LINES 4'h5
`define LFT_PIDX_WIDTH_LO 4'h6
`define LFT_PIDX_WIDTH_HI 4'h7
`define LFT_P1_DUAL_BIT 3
`define LFT_DISPLAY_ENABLE_CMD_BIT 0

`define LFT_RST_LINE_LEN 8'h00
`define LFT_RST_FRAME_LINES 8'h00
`define LFT_RST_LINE_BYTES 8'h00
`define LFT_RST_WIDTH 16'h0000

`define LFT_BYTE_CYCLES 4

`define LFT_RESP_OKAY 2'b00
`define LFT_RESP_SLVERR 2'b10

`endif

// File: rtl/lft_pkg.sv
/*
  types for the line/frame timing and standby block.
  assumes lft_cfg.svh is on the include path.
*/
`default_nettype none
package lft_pkg;
  typedef enum logic [2:0] {
    LFT_ST_RUN = 3'b001,
    LFT_ST_BLANK = 3'b010,
    LFT_ST_SLEEP = 3'b100
  } lft_state_t;

  typedef struct packed {
    logic [15:0] mem_addr;
    logic line_start;
    logic frame_start;
    logic blank_data;
  } lft_scan_t;
endpackage
`default_nettype wire

// File: rtl/lft_timing.sv
/*
  line and frame timing with standby entry and wake, behind an axi4-lite register slave.
  assumes a single clock sys_clk, async active-high sys_rst, and a master that keeps
  axi4-lite valid/ready rules; command and parameter bytes arrive through the host port.
*/
// Overview of operation
// RULE_01 - line lasts total_line_length plus one bytes
// RULE_02 - host keeps line length above active bytes+4
// RULE_03 - host picks line length from oscillator rate
// RULE_04 - frame has frame_line_count plus one lines
// RULE_05 - dual screen needs odd frame line count
// RULE_06 - virtual width low byte is least significant
// RULE_07 - standby entry command has no parameters
// RULE_08 - after blank frame, halt oscillator, sleep
// RULE_09 - standby blanks columns, lowers row driver disable
// RULE_10 - row disable low one to two frames later
// RULE_11 - registers unchanged while sleeping
// RULE_12 - memory control outputs hold during sleep
// RULE_13 - setup command plus first byte wakes device
// RULE_14 - host then sends display enable command
// RULE_15 - host bus lines released while sleeping
// RULE_16 - host keeps active line bytes within 0..239
// RULE_17 - standby entry is instruction byte 0x53
`default_nettype none
`include "lft_cfg.svh"
module lft_timing #(
  parameter int BYTE_CYCLES = `LFT_BYTE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sys_ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output lft_pkg::lft_scan_t scan,
  output logic row_driver_disable,
  output logic osc_run,
  output logic host_bus_oe
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `LFT_ADDR_HOST_PORT) || (a == `LFT_ADDR_TIMING) ||
             (a == `LFT_ADDR_STATUS) || (a == `LFT_ADDR_WIDTH);
  endfunction

  lft_pkg::lft_state_t state;
  logic [7:0] total_line_length;
  logic [7:0] frame_line_count;
  logic [7:0] active_line_bytes;
  logic [15:0] virtual_screen_width;
  logic dual_screen_select;
  logic display_on;
  logic [7:0] last_byte;
  logic [7:0] cmd_q;
  logic [3:0] pidx;
  logic [7:0] col;
  logic [7:0] line;
  logic [$clog2(BYTE_CYCLES+1)-1:0] div;
  logic byte_tick;
  logic line_end;
  logic frame_end;
  logic blank_frames;
  logic [15:0] line_base;

  // axi write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic host_wr;
  logic host_instr;
  logic [7:0] host_byte;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign host_wr = wr_fire && (aw_addr == `LFT_ADDR_HOST_PORT) && w_strb[0];
  assign host_instr = w_data[`LFT_PORT_INSTR_BIT] && w_strb[1];
  assign host_byte = w_data[7:0];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFT_RESP_OKAY;
    end else if (sys_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `LFT_RESP_OKAY : `LFT_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LFT_RESP_OKAY;
    end else if (sys_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `LFT_RESP_OKAY : `LFT_RESP_SLVERR;
        case (s_axi_araddr)
          `LFT_ADDR_HOST_PORT: s_axi_rdata <= {24'h00_0000, last_byte};
          `LFT_ADDR_TIMING: begin
            s_axi_rdata <= {7'h00, dual_screen_select, active_line_bytes,
                            frame_line_count, total_line_length};
          end
          `LFT_ADDR_STATUS: begin
            s_axi_rdata <= {8'h00, col, line, 3'h0, display_on, scan.blank_data,
                            row_driver_disable, osc_run, state == lft_pkg::LFT_ST_SLEEP};
          end
          `LFT_ADDR_WIDTH: s_axi_rdata <= {16'h0000, virtual_screen_width};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // command decode and parameter capture
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q <= 8'h00;
      pidx <= 4'h0;
      last_byte <= 8'h00;
      total_line_length <= `LFT_RST_LINE_LEN;
      frame_line_count <= `LFT_RST_FRAME_LINES;
      active_line_bytes <= `LFT_RST_LINE_BYTES;
      virtual_screen_width <= `LFT_RST_WIDTH;
      dual_screen_select <= 1'b0;
      display_on <= 1'b0;
    end else if (sys_ce && host_wr) begin
      last_byte <= host_byte;
      if (host_instr) begin
        cmd_q <= host_byte;
        pidx <= 4'h0;
        if (host_byte == `LFT_CMD_STANDBY_ENTRY && state == lft_pkg::LFT_ST_RUN) begin // RULE_07
          display_on <= 1'b0;
        end
      end else begin
        if (pidx != 4'hf) begin
          pidx <= pidx + 4'h1;
        end
        if (state == lft_pkg::LFT_ST_RUN) begin // RULE_11
          if (cmd_q == `LFT_CMD_SYSTEM_SETUP) begin
            case (pidx)
              `LFT_PIDX_FIRST: dual_screen_select <= host_byte[`LFT_P1_DUAL_BIT];
              `LFT_PIDX_LINE_BYTES: active_line_bytes <= host_byte;
              `LFT_PIDX_LINE_LEN: total_line_length <= host_byte; // RULE_01
              `LFT_PIDX_FRAME_LINES: frame_line_count <= host_byte; // RULE_04
              `LFT_PIDX_WIDTH_LO: virtual_screen_width[7:0] <= host_byte; // RULE_06
              `LFT_PIDX_WIDTH_HI: virtual_screen_width[15:8] <= host_byte; // RULE_06
              default: ;
            endcase
          end else if (cmd_q == `LFT_CMD_DISPLAY_ENABLE && pidx == `LFT_PIDX_FIRST) begin
            display_on <= host_byte[`LFT_DISPLAY_ENABLE_CMD_BIT];
          end
        end
      end
    end
  end

  // standby sequencer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= lft_pkg::LFT_ST_RUN;
      blank_frames <= 1'b0;
      row_driver_disable <= 1'b1;
    end else if (sys_ce) begin
      case (state)
        lft_pkg::LFT_ST_RUN: begin
          if (host_wr && host_instr && host_byte == `LFT_CMD_STANDBY_ENTRY) begin // RULE_17
            state <= lft_pkg::LFT_ST_BLANK; // RULE_09
            blank_frames <= 1'b0;
          end
        end
        lft_pkg::LFT_ST_BLANK: begin
          if (frame_end) begin
            blank_frames <= 1'b1;
            if (blank_frames) begin
              row_driver_disable <= 1'b0; // RULE_10
              state <= lft_pkg::LFT_ST_SLEEP; // RULE_08
            end
          end
        end
        lft_pkg::LFT_ST_SLEEP: begin
          if (host_wr && !host_instr && cmd_q == `LFT_CMD_SYSTEM_SETUP &&
              pidx == `LFT_PIDX_FIRST) begin // RULE_13
            state <= lft_pkg::LFT_ST_RUN;
            row_driver_disable <= 1'b1;
          end
        end
        default: state <= lft_pkg::LFT_ST_RUN;
      endcase
    end
  end

  assign osc_run = (state != lft_pkg::LFT_ST_SLEEP); // RULE_08
  assign host_bus_oe = (state != lft_pkg::LFT_ST_SLEEP); // RULE_15

  // byte period from the internal oscillator
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div <= '0;
    end else if (sys_ce && osc_run) begin
      if (byte_tick) begin
        div <= '0;
      end else begin
        div <= div + 1'b1;
      end
    end
  end

  assign byte_tick = osc_run && (div == ($clog2(BYTE_CYCLES+1))'(BYTE_CYCLES - 1));
  assign line_end = byte_tick && (col >= total_line_length);
  assign frame_end = line_end && (line >= frame_line_count);

  // column and line counters
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      col <= 8'h00;
      line <= 8'h00;
      line_base <= 16'h0000;
    end else if (sys_ce && byte_tick) begin
      if (line_end) begin
        col <= 8'h00; // RULE_01
        if (frame_end) begin
          line <= 8'h00; // RULE_04
          line_base <= 16'h0000;
        end else begin
          line <= line + 8'h01;
          line_base <= line_base + virtual_screen_width; // RULE_06
        end
      end else begin
        col <= col + 8'h01;
      end
    end
  end

  // scan outputs, frozen with the oscillator during sleep
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan <= '0;
    end else if (sys_ce && osc_run) begin // RULE_12
      scan.mem_addr <= line_base + {8'h00, col};
      scan.line_start <= byte_tick && col == 8'h00;
      scan.frame_start <= byte_tick && col == 8'h00 && line == 8'h00;
      scan.blank_data <= (state != lft_pkg::LFT_ST_RUN) || !display_on ||
                         (col > active_line_bytes); // RULE_09
    end
  end

endmodule // lft_timing
`default_nettype wire

// File: tb/lft_timing_assertions.sv
/*
  checker for lft_timing: standby, sleep and bus hold relations.
  assumes it is bound to lft_timing and sees its ports only.
*/
`default_nettype none
module lft_timing_check (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire lft_pkg::lft_scan_t scan,
  input wire logic row_driver_disable,
  input wire logic osc_run,
  input wire logic host_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] n_fs;
  // blank frame starts seen before sleep
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) n_fs <= 2'h0;
    else if (!scan.blank_data || !osc_run) n_fs <= 2'h0;
    else if (scan.frame_start && n_fs != 2'h3) n_fs <= n_fs + 2'h1;
  sequence s_enter_sleep;
    osc_run ##1 !osc_run;
  endsequence
  sequence s_asleep;
    !osc_run ##1 !osc_run;
  endsequence
  AST_BLANK_FRAME: assert property (s_enter_sleep |-> n_fs != 2'h0)
    else $error("sleep entered without a blank frame");
  AST_BUS_RELEASE: assert property (host_bus_oe == osc_run)
    else $error("host bus drive does not follow run state");
  AST_ROW_OFF: assert property (!osc_run |-> !row_driver_disable && scan.blank_data)
    else $error("sleep without blank data and row disable");
  AST_ROW_FALL: assert property ($fell(row_driver_disable) |-> !osc_run)
    else $error("row disable fell outside sleep entry");
  AST_HOLD: assert property (s_asleep |-> $stable(scan))
    else $error("memory control outputs moved in sleep");
  AST_WAKE: assert property ($rose(osc_run) |-> ##[0:2] row_driver_disable)
    else $error("row drivers not enabled on wake");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed before taken");
endmodule // lft_timing_check
bind lft_timing lft_timing_check chk_i (.sys_clk, .sys_rst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .scan, .row_driver_disable, .osc_run, .host_bus_oe);
`default_nettype wire

// File: tb/lft_host.sv
/*
  host model: axi4-lite master writing command and parameter bytes.
  assumes the bench calls one task at a time.
*/
`default_nettype none
module lft_host (
  input wire logic sys_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_wdata <= ~d;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(8'h00, {23'h0, 1'b1, c});
  endtask
  task automatic par(input logic [7:0] b);
    wr(8'h00, {24'h0, b});
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
endmodule // lft_host
`default_nettype wire

// File: tb/lft_timing_test.sv
/*
  testbench for lft_timing: setup, line and frame periods, standby, sleep and wake.
  assumes lft_host drives the bus and the checker is bound to the design.
*/
`default_nettype none
module lft_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic row_driver_disable, osc_run, host_bus_oe, d;
  logic ce = 1'b1;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] s_axi_awaddr, s_axi_araddr, len, fl, act;
  logic [7:0] p[8];
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_rresp;
  lft_pkg::lft_scan_t scan, sv;
  logic [33:0] q[$];
  int n_mismatch = 0, tests_run = 0, seed = 32'h398cd7a0, t, f;
  lft_timing #(.BYTE_CYCLES(1)) uut (.sys_clk, .sys_rst, .sys_ce(ce), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .scan, .row_driver_disable, .osc_run, .host_bus_oe);
  lft_host host (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] e);
    tests_run++;
    if (got !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  always @(posedge sys_clk)
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
  task automatic rx(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    host.rd(a);
  endtask
  task automatic per(input bit fr, input int e);
    int n = 0;
    do @(posedge sys_clk); while ((fr ? scan.frame_start : scan.line_start) !== 1'b1);
    do begin
      @(posedge sys_clk);
      n++;
    end while ((fr ? scan.frame_start : scan.line_start) !== 1'b1);
    chk(34'(n), 34'(e));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // whole run needs under two thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude;
  end
  initial begin
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rx(8'h04, 34'h0);
    rx(8'h10, {2'b10, 32'h0});
    for (int i = 0; i < 2; i++) begin
      d = i[0];
      act = 8'($random(seed)) & 8'h07;
      len = act + 8'd4 + (8'($random(seed)) & 8'h03);
      fl = (8'($random(seed)) & 8'h07) | 8'h01;
      p = '{{4'h0, d, 3'h0}, 8'h0, 8'h0, act, len, fl, 8'($random(seed)), 8'($random(seed))};
      host.cmd(8'h40);
      foreach (p[k]) host.par(p[k]);
      rx(8'h04, {9'h0, d, act, fl, len});
      rx(8'h0c, {18'h0, p[7], p[6]});
      per(1'b0, len + 1);
      per(1'b1, (len + 1) * (fl + 1));
      $display("setup pass %0d done", i);
    end
    wstrb <= 4'h2;
    host.cmd(8'h53);
    wstrb <= 4'hf;
    repeat (4) @(posedge sys_clk);
    chk({osc_run, row_driver_disable}, 34'h3);
    rx(8'h00, 34'(p[7]));
    ce <= 1'b0;
    @(posedge sys_clk);
    sv = scan;
    repeat (10) @(posedge sys_clk);
    chk(34'(scan), 34'(sv));
    ce <= 1'b1;
    $display("strobe and enable done");
    f = (len + 1) * (fl + 1);
    host.cmd(8'h53);
    t = 0;
    while (row_driver_disable !== 1'b0 && t < 4000) begin
      @(posedge sys_clk);
      t++;
    end
    chk(34'(t + 2 >= f && t <= 2 * f + 4), 34'h1);
    chk({osc_run, host_bus_oe, scan.blank_data}, 34'h1);
    sv = scan;
    host.par(8'h55);
    repeat (20) @(posedge sys_clk);
    chk(34'(scan), 34'(sv));
    rx(8'h04, {9'h0, d, act, fl, len});
    $display("standby done");
    host.cmd(8'h40);
    host.par(8'h00);
    repeat (4) @(posedge sys_clk);
    chk({osc_run, host_bus_oe, row_driver_disable, scan.blank_data}, 34'hf);
    rx(8'h04, {9'h0, d, act, fl, len});
    host.cmd(8'h59);
    host.par(8'h01);
    repeat (f + 4) @(posedge sys_clk);
    do @(posedge sys_clk); while (scan.line_start !== 1'b1);
    chk(34'(scan.blank_data), 34'h0);
    $display("wake done");
    wait (q.size() == 0);
    repeat (2) @(posedge sys_clk);
    conclude;
  end
endmodule // lft_timing_test
`default_nettype wire
